// ===== inc/uart_irq_pkg.sv
package uart_irq_pkg;
    // register byte offsets on the AXI4-Lite port
    localparam logic [7:0] OFS_IRQ_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_SER_CTRL  = 8'h04;
    localparam logic [7:0] OFS_SER_STAT  = 8'h08;

    // primary_irq_control_0 fields
    localparam int B_GLOBAL_EN   = 0;
    localparam int B_EXT_PIN_EN  = 1;
    localparam int B_SERIAL_EN   = 2;
    localparam int B_TB0_EN      = 3;
    localparam int B_EXT_PIN_FLG = 4;
    localparam int B_SERIAL_FLG  = 5;
    localparam int B_TB0_FLG     = 6;
    localparam logic [7:0] IRQ_CTRL0_RESET = 8'h00;
    localparam logic [7:0] IRQ_CTRL0_WMASK = 8'h7F;

    // serial control fields
    localparam int C_TX_EMPTY_EN = 0;
    localparam int C_TX_IDLE_EN  = 1;
    localparam int C_RX_IRQ_EN   = 2;
    localparam int C_ADDR_DET_EN = 3;
    localparam int C_WAKE_EN     = 4;
    localparam int C_UNIT_EN     = 5;
    localparam int C_RX_EN       = 6;
    localparam int C_PARITY_EN   = 7;
    localparam int C_NINE_BIT    = 8;
    localparam int SER_CTRL_W    = 9;
    localparam logic [SER_CTRL_W-1:0] SER_CTRL_RESET = 9'h000;

    // serial status fields (read only)
    localparam int S_TX_EMPTY  = 0;
    localparam int S_TX_IDLE   = 1;
    localparam int S_RX_AVAIL  = 2;
    localparam int S_OVERRUN   = 3;
    localparam int S_CLOCK_ON  = 4;
    localparam int S_STARTUP   = 5;
    localparam int S_WAKE_WAIT = 6;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // register select codes
    localparam logic [1:0] SEL_CTRL0 = 2'h0;
    localparam logic [1:0] SEL_SCTRL = 2'h1;
    localparam logic [1:0] SEL_SSTAT = 2'h2;
    localparam logic [1:0] SEL_NONE  = 2'h3;

    // start-up interval after a resume, rounded up to whole clocks
    localparam int CLK_PERIOD_NS   = 8;
    localparam int STARTUP_TIME_NS = 16000;
    localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_W       = 12;

    typedef enum logic [1:0] {WK_IDLE, WK_WAIT_CLK, WK_STARTUP} wake_state_t;
endpackage

// ===== design/uart_irq_logic.sv
module uart_irq_logic
    import uart_irq_pkg::*;
#(
    parameter int STARTUP_COUNT = STARTUP_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        tx_empty_flag,
    input  wire logic        tx_idle_flag,
    input  wire logic        receive_available_flag,
    input  wire logic        overrun_flag,
    input  wire logic        rx_bit8,
    input  wire logic        rx_bit9,
    input  wire logic        serial_line,
    input  wire logic        uart_clock_on,
    input  wire logic        stack_full,
    input  wire logic        irq_serviced,
    input  wire logic        serial_vector_taken,
    output logic             uart_irq_n,
    output logic             serial_vector_req,
    output logic             resume_request,
    output logic             discard_rx,
    output logic             uart_run
);
    // decode shared by the read and write paths
    function automatic logic [1:0] reg_sel(input logic [7:0] addr);
        case (addr)
            OFS_IRQ_CTRL0: reg_sel = SEL_CTRL0;
            OFS_SER_CTRL:  reg_sel = SEL_SCTRL;
            OFS_SER_STAT:  reg_sel = SEL_SSTAT;
            default:       reg_sel = SEL_NONE;
        endcase
    endfunction

    logic [7:0]            irq_ctrl0;
    logic [SER_CTRL_W-1:0] ser_ctrl;
    logic                  aw_held, w_held;
    logic [7:0]            aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic [3:0]            src_prev;
    logic                  rx_flag_prev;
    logic                  line_s1, line_s2, line_s3;
    wake_state_t           wake_state;
    logic [STARTUP_W-1:0]  startup_cnt;
    logic                  next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0]            next_aw_addr, next_irq_ctrl0;
    logic [31:0]           next_w_data, next_rdata;
    logic [3:0]            next_w_strb;
    logic [1:0]            next_bresp, next_rresp;
    logic [SER_CTRL_W-1:0] next_ser_ctrl;
    wake_state_t           next_wake_state;
    logic [STARTUP_W-1:0]  next_startup_cnt;
    logic                  next_irq_n, next_resume;
    logic [3:0]            src_now;
    logic [31:0]           status_word;
    logic                  top_bit, rx_rise, ev_addr, ev_rxdata, ev_wake, serial_event, line_fall;
    logic                  wake_armed, do_write;

    // AXI handshakes are combinational; one write and one read in flight
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign serial_vector_req = irq_ctrl0[B_GLOBAL_EN] && irq_ctrl0[B_SERIAL_EN]
                               && irq_ctrl0[B_SERIAL_FLG] && !stack_full;
    assign discard_rx = (wake_state != WK_IDLE);
    // the serial core only steps while its clock runs; it freezes, never resets, when off
    assign uart_run   = uart_clock_on && (wake_state != WK_STARTUP);

    // source conditions, each masked before edge detection except the address-detect edge, which uses the raw flag
    always_comb begin
        top_bit = ser_ctrl[C_NINE_BIT] ? rx_bit9 : rx_bit8;
        src_now[0] = tx_empty_flag && ser_ctrl[C_TX_EMPTY_EN];
        src_now[1] = tx_idle_flag && ser_ctrl[C_TX_IDLE_EN];
        src_now[2] = receive_available_flag && ser_ctrl[C_RX_IRQ_EN];
        src_now[3] = overrun_flag && ser_ctrl[C_RX_IRQ_EN];
        rx_rise   = src_now[2] && !src_prev[2];
        // address detect qualifies rx data on the top received bit
        ev_rxdata = rx_rise && (!ser_ctrl[C_ADDR_DET_EN] || top_bit);
        // raw flag edge: with the receiver mask off a masked edge would never fire
        ev_addr   = receive_available_flag && !rx_flag_prev && ser_ctrl[C_ADDR_DET_EN] && top_bit;
        ev_wake   = (wake_state == WK_STARTUP) && (startup_cnt == STARTUP_W'(0))
                    && irq_ctrl0[B_GLOBAL_EN] && irq_ctrl0[B_SERIAL_EN];
        serial_event = (src_now[0] && !src_prev[0]) || (src_now[1] && !src_prev[1])
                       || ev_rxdata || (src_now[3] && !src_prev[3]) || ev_addr || ev_wake;
        line_fall  = line_s3 && !line_s2;
        wake_armed = !uart_clock_on && ser_ctrl[C_WAKE_EN] && ser_ctrl[C_UNIT_EN]
                     && ser_ctrl[C_RX_EN] && ser_ctrl[C_RX_IRQ_EN];
        status_word = 32'h0000_0000;
        status_word[S_TX_EMPTY]  = tx_empty_flag;
        status_word[S_TX_IDLE]   = tx_idle_flag;
        status_word[S_RX_AVAIL]  = receive_available_flag;
        status_word[S_OVERRUN]   = overrun_flag;
        status_word[S_CLOCK_ON]  = uart_clock_on;
        status_word[S_STARTUP]   = (wake_state == WK_STARTUP);
        status_word[S_WAKE_WAIT] = (wake_state == WK_WAIT_CLK);
    end

    // register file and bus next state
    always_comb begin
        next_aw_held   = aw_held;
        next_w_held    = w_held;
        next_aw_addr   = aw_addr;
        next_w_data    = w_data;
        next_w_strb    = w_strb;
        next_bvalid    = s_axi_bvalid;
        next_bresp     = s_axi_bresp;
        next_rvalid    = s_axi_rvalid;
        next_rdata     = s_axi_rdata;
        next_rresp     = s_axi_rresp;
        next_irq_ctrl0 = irq_ctrl0;
        next_ser_ctrl  = ser_ctrl;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            case (reg_sel(aw_addr))
                SEL_CTRL0: if (w_strb[0]) begin
                    next_irq_ctrl0 = w_data[7:0] & IRQ_CTRL0_WMASK;
                end
                SEL_SCTRL: begin
                    // control bits change only here, never on clock stop
                    if (w_strb[0]) begin
                        next_ser_ctrl[7:0] = w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        next_ser_ctrl[C_NINE_BIT] = w_data[C_NINE_BIT];
                    end
                end
                SEL_SSTAT: ;                            // flags ignore writes
                default: next_bresp = RESP_DECERR;
            endcase
        end
        // servicing clears the global enable; hardware set beats both clears
        if (irq_serviced) begin
            next_irq_ctrl0[B_GLOBAL_EN] = 1'b0;
        end
        if (serial_vector_taken) begin
            next_irq_ctrl0[B_SERIAL_FLG] = 1'b0;
        end
        if (serial_event) begin
            next_irq_ctrl0[B_SERIAL_FLG] = 1'b1;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                SEL_CTRL0: next_rdata = {24'h000000, irq_ctrl0};
                SEL_SCTRL: next_rdata = {23'h000000, ser_ctrl};
                SEL_SSTAT: next_rdata = status_word;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
            irq_ctrl0    <= IRQ_CTRL0_RESET;
            ser_ctrl     <= SER_CTRL_RESET;
        end else begin
            aw_held      <= next_aw_held;
            w_held       <= next_w_held;
            aw_addr      <= next_aw_addr;
            w_data       <= next_w_data;
            w_strb       <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
            irq_ctrl0    <= next_irq_ctrl0;
            ser_ctrl     <= next_ser_ctrl;
        end
    end

    // resume sequencer: aclk keeps running while the serial clock is off
    always_comb begin
        next_wake_state  = wake_state;
        next_startup_cnt = startup_cnt;
        next_resume      = 1'b0;
        next_irq_n       = !(serial_event && irq_ctrl0[B_SERIAL_EN]);
        case (wake_state)
            WK_IDLE: if (wake_armed && line_fall) begin
                next_resume     = 1'b1;
                next_wake_state = WK_WAIT_CLK;
            end
            WK_WAIT_CLK: if (uart_clock_on) begin
                next_wake_state  = WK_STARTUP;
                next_startup_cnt = STARTUP_W'(STARTUP_COUNT - 1);
            end
            WK_STARTUP: begin
                if (startup_cnt == STARTUP_W'(0)) begin
                    next_wake_state = WK_IDLE;
                end else begin
                    next_startup_cnt = startup_cnt - STARTUP_W'(1);
                end
            end
            default: next_wake_state = WK_IDLE;
        endcase
    end

    // the line synchroniser: only s2 and s3 feed the edge detector
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_s1        <= 1'b1;
            line_s2        <= 1'b1;
            line_s3        <= 1'b1;
            src_prev       <= 4'h0;
            rx_flag_prev   <= 1'b0;
            wake_state     <= WK_IDLE;
            startup_cnt    <= '0;
            uart_irq_n     <= 1'b1;
            resume_request <= 1'b0;
        end else begin
            line_s1        <= serial_line;
            line_s2        <= line_s1;
            line_s3        <= line_s2;
            src_prev       <= src_now;
            rx_flag_prev   <= receive_available_flag;
            wake_state     <= next_wake_state;
            startup_cnt    <= next_startup_cnt;
            uart_irq_n     <= next_irq_n;
            resume_request <= next_resume;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    irq_pulse_a: assert property (!uart_irq_n |=> uart_irq_n)
        else $error("request pulse lasted more than one cycle");
    vector_gate_a: assert property (serial_vector_req |-> irq_ctrl0[B_GLOBAL_EN] && irq_ctrl0[B_SERIAL_EN]
        && !stack_full) else $error("vector requested while gated");
    flag_set_a: assert property (!uart_irq_n |-> irq_ctrl0[B_SERIAL_FLG] && $past(irq_ctrl0[B_SERIAL_EN]))
        else $error("pulse without flag or enable");
    emi_clear_a: assert property (irq_serviced |=> !irq_ctrl0[B_GLOBAL_EN])
        else $error("global enable not cleared on service");
    addr_qual_a: assert property (ev_rxdata && ser_ctrl[C_ADDR_DET_EN] |-> top_bit)
        else $error("rx data request without top bit");
    rx_plain_a: assert property (rx_rise && !ser_ctrl[C_ADDR_DET_EN] && irq_ctrl0[B_SERIAL_EN]
        |=> !uart_irq_n) else $error("rx flag rise gave no pulse");
    resume_cond_a: assert property (resume_request |-> $past(wake_armed) && $past(line_fall))
        else $error("resume without armed falling edge");
    // start-up lasts STARTUP_COUNT cycles: 2000 by default, four in the testbench
    startup_disc_a: assert property ($rose(wake_state == WK_STARTUP) |-> discard_rx [*4])
        else $error("rx not discarded in start-up");
    wake_gate_a: assert property (ev_wake |-> irq_ctrl0[B_GLOBAL_EN] && irq_ctrl0[B_SERIAL_EN])
        else $error("wake interrupt without enables");
    write_resp_a: assert property (do_write |=> s_axi_bvalid) else $error("write response missing");

    resume_c: cover property (resume_request ##[1:1000] (wake_state == WK_STARTUP));
    wake_irq_c: cover property (ev_wake ##1 !uart_irq_n);
    addr_c: cover property (ev_addr ##1 !uart_irq_n);
    vector_c: cover property (serial_vector_req ##1 irq_serviced);
endmodule // uart_irq_logic

// ===== tb/cpu_model.sv
// stands in for the processor core and its interrupt controller
module cpu_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       serial_vector_req,
    input  wire logic       full,
    input  wire logic [3:0] lag,
    output logic            stack_full,
    output logic            irq_serviced,
    output logic            serial_vector_taken
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] wait_cnt;

    // vector only on a live request; lag models a core still finishing an instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stack_full          <= 1'b0;
            irq_serviced        <= 1'b0;
            serial_vector_taken <= 1'b0;
            wait_cnt            <= 4'h0;
        end else begin
            stack_full          <= full;
            irq_serviced        <= 1'b0;
            serial_vector_taken <= 1'b0;
            if (serial_vector_req && !irq_serviced) begin
                if (wait_cnt == lag) begin
                    irq_serviced        <= 1'b1;
                    serial_vector_taken <= 1'b1;
                    wait_cnt            <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule // cpu_model

// ===== tb/tb.sv
module tb
    import uart_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, lag;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        tx_empty_flag, tx_idle_flag, receive_available_flag, overrun_flag, rx_bit8, rx_bit9;
    logic        serial_line, uart_clock_on, stack_full, irq_serviced, serial_vector_taken, full;
    logic        uart_irq_n, serial_vector_req, resume_request, discard_rx, uart_run;
    int          error_cnt, total_checks;
    int          irq_cnt = 0;
    int          rs_cnt  = 0;

    uart_irq_logic #(.STARTUP_COUNT(4)) dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .tx_empty_flag, .tx_idle_flag, .receive_available_flag, .overrun_flag, .rx_bit8,
        .rx_bit9, .serial_line, .uart_clock_on, .stack_full, .irq_serviced, .serial_vector_taken,
        .uart_irq_n, .serial_vector_req, .resume_request, .discard_rx, .uart_run);
    cpu_model cpu (.aclk, .aresetn, .serial_vector_req, .full, .lag, .stack_full, .irq_serviced,
        .serial_vector_taken);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // count request pulses and resume pulses; scenarios compare deltas
    always @(posedge aclk) begin
        if (aresetn && !uart_irq_n) irq_cnt <= irq_cnt + 1;
        if (aresetn && resume_request) rs_cnt <= rs_cnt + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin ad = 1; s_axi_awvalid <= 1'b0; end
            if (!wd && s_axi_wready) begin wd = 1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(resp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(resp));
    endtask

    // raise one source for a while and count the request pulses it caused
    task automatic fire(input int src, input int exp);
        int base;
        base = irq_cnt;
        @(posedge aclk);
        case (src)
            0: tx_empty_flag <= 1'b1;
            1: tx_idle_flag <= 1'b1;
            2: receive_available_flag <= 1'b1;
            default: overrun_flag <= 1'b1;
        endcase
        repeat (3) @(posedge aclk);
        chk(32'(irq_cnt - base), 32'(exp));
        {tx_empty_flag, tx_idle_flag, receive_available_flag, overrun_flag} <= 4'h0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_regs;
        rd(OFS_IRQ_CTRL0, {24'h0, IRQ_CTRL0_RESET}, RESP_OKAY);
        rd(8'h0C, 32'h0, RESP_DECERR);
        wr(8'h0C, 32'hFFFFFFFF, RESP_DECERR);
        wr(OFS_SER_STAT, 32'hFF, RESP_OKAY);
        rd(OFS_SER_STAT, 32'h10, RESP_OKAY);
        wr(OFS_IRQ_CTRL0, 32'h8A, RESP_OKAY);
        rd(OFS_IRQ_CTRL0, 32'h0A, RESP_OKAY);
        wr(OFS_IRQ_CTRL0, 32'h0, RESP_OKAY);
        $display("test regs done");
    endtask

    task automatic t_tx;
        wr(OFS_IRQ_CTRL0, 32'h04, RESP_OKAY);
        wr(OFS_SER_CTRL, 32'h03, RESP_OKAY);
        fire(0, 1);
        fire(1, 1);
        wr(OFS_SER_CTRL, 32'h00, RESP_OKAY);
        fire(0, 0);
        wr(OFS_IRQ_CTRL0, 32'h00, RESP_OKAY);
        wr(OFS_SER_CTRL, 32'h03, RESP_OKAY);
        fire(1, 0);
        rd(OFS_IRQ_CTRL0, 32'h20, RESP_OKAY);
        $display("test tx done");
    endtask

    task automatic t_vec;
        @(posedge aclk);
        full <= 1'b1;
        wr(OFS_IRQ_CTRL0, 32'h05, RESP_OKAY);
        wr(OFS_SER_CTRL, 32'h01, RESP_OKAY);
        fire(0, 1);
        chk(32'(serial_vector_req), 32'h0);
        rd(OFS_IRQ_CTRL0, 32'h25, RESP_OKAY);
        @(posedge aclk);
        full <= 1'b0;
        repeat (12) @(posedge aclk);
        rd(OFS_IRQ_CTRL0, 32'h04, RESP_OKAY);
        $display("test vector done");
    endtask

    task automatic t_addr;
        logic [3:0] nine, b8, b9, ex;
        nine = 4'b1100; b8 = 4'b0110; b9 = 4'b1001; ex = 4'b1010;
        wr(OFS_IRQ_CTRL0, 32'h04, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SER_CTRL, {23'h0, nine[i], 8'h0C}, RESP_OKAY);
            @(posedge aclk);
            rx_bit8 <= b8[i];
            rx_bit9 <= b9[i];
            fire(2, int'(ex[i]));
        end
        // top bit 8 is low here; address detect off must still request
        wr(OFS_SER_CTRL, 32'h04, RESP_OKAY);
        fire(2, 1);
        // address detect alone, receiver mask off: one pulse per word, not one per cycle
        wr(OFS_SER_CTRL, 32'h08, RESP_OKAY);
        @(posedge aclk);
        rx_bit8 <= 1'b1;
        fire(2, 1);
        wr(OFS_SER_CTRL, 32'h04, RESP_OKAY);
        fire(3, 1);
        wr(OFS_SER_CTRL, 32'h00, RESP_OKAY);
        fire(3, 0);
        $display("test address done");
    endtask

    // resume with and without the global enable; only the first may interrupt
    task automatic t_wake;
        int bi, br;
        for (int g = 1; g >= 0; g--) begin
            wr(OFS_IRQ_CTRL0, 32'h04 | 32'(g), RESP_OKAY);
            wr(OFS_SER_CTRL, 32'h74, RESP_OKAY);
            @(posedge aclk);
            uart_clock_on <= 1'b0;
            rd(OFS_SER_CTRL, 32'h74, RESP_OKAY);
            bi = irq_cnt;
            br = rs_cnt;
            @(posedge aclk);
            serial_line <= 1'b0;
            repeat (8) @(posedge aclk);
            chk(32'(rs_cnt - br), 32'h1);
            chk(32'(discard_rx), 32'h1);
            @(posedge aclk);
            uart_clock_on <= 1'b1;
            serial_line <= 1'b1;
            repeat (2) @(posedge aclk);
            chk(32'(uart_run), 32'h0);
            chk(32'(irq_cnt - bi), 32'h0);
            repeat (10) @(posedge aclk);
            chk(32'(irq_cnt - bi), 32'(g));
            chk(32'(discard_rx), 32'h0);
        end
        $display("test wake done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // the scenarios take under a thousand cycles; anything far beyond is a hang
    initial begin
        repeat (6000) @(posedge aclk);
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        aresetn = 1'b0; lag = 4'h3; full = 1'b0; error_cnt = 0; total_checks = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        {tx_empty_flag, tx_idle_flag, receive_available_flag, overrun_flag, rx_bit8, rx_bit9} = 6'h00;
        serial_line = 1'b1;
        uart_clock_on = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_tx;
        t_vec;
        t_addr;
        t_wake;
        tally_and_finish;
    end
endmodule // tb
